// ===== dpg_ctrl_regs.sv
// register bank that holds the pll clock multiplier, i and q dac and
// first auxiliary dac controls and presents them to the analog edge.
// assumes a serial port engine ahead of it that assembles whole words and
// issues one-cycle read and write strobes on clk_i; the analog periphery
// reads the field outputs as static levels.
//
// Operation
// RULE_01 - pll off: sample clock from reference input
// RULE_02 - pll on: sample clock multiplied by pll
// RULE_03 - vco divider codes give ratios 1,2,4,8
// RULE_04 - loop divider codes give ratios 2,4,8,16
// RULE_05 - control voltage code read-only, 011 centred
// RULE_06 - software sets loop bandwidth, advised 01111
// RULE_07 - software sets pll bias, advised 011
// RULE_08 - band select chooses vco frequency band
// RULE_09 - software sets vco drive, advised 11
// RULE_10 - i dac sleep bit, default active
// RULE_11 - i dac power-down bit, default active
// RULE_12 - i dac ten-bit gain to periphery
// RULE_13 - aux dac sign selects output pin
// RULE_14 - aux dac direction: source or sink
// RULE_15 - aux dac power-down bit, default active
// RULE_16 - aux dac ten-bit data to periphery
// RULE_17 - i dac bits 13..10 reserved
// RULE_18 - register bits routed straight to periphery
// RULE_19 - q dac register mirrors i dac
`timescale 1ns/1ns
`include "dpg_consts.svh"

module dpg_ctrl_regs (
    // clock and reset
    input  wire logic            clk_i,
    input  wire logic            reset_n_i,
    // register port from the serial port engine
    input  dpg_pkg::dpg_req_t    req_i,
    output dpg_pkg::dpg_rsp_t    rsp_o,
    // analog status input
    input  wire logic [2:0]      vco_volt_level_i,
    // pll controls to the analog periphery
    output dpg_pkg::dpg_pll_t    pll_o,
    output logic                 dac_clk_from_pll_o,
    output logic [`DPG_VRATIO_W-1:0] vco_div_ratio_o,
    output logic [`DPG_LRATIO_W-1:0] loop_div_ratio_o,
    // main dac controls
    output dpg_pkg::dpg_dac_t    i_dac_o,
    output dpg_pkg::dpg_dac_t    q_dac_o,
    output logic                 i_dac_active_o,
    output logic                 q_dac_active_o,
    // first auxiliary dac controls
    output dpg_pkg::dpg_aux_t    aux1_o,
    output logic                 aux1_pos_pin_en_o,
    output logic                 aux1_neg_pin_en_o,
    output logic                 aux1_active_o
);

    import dpg_pkg::*;

    // stored register fields
    logic [4:0]  loop_bw;        // loop filter bandwidth
    logic        pll_en;         // clock multiplier enable
    logic [1:0]  vco_div;        // vco output divider code
    logic [1:0]  loop_div;       // loop divider code
    logic [2:0]  bias;           // vco bias current
    logic [5:0]  band;           // vco band select
    logic [1:0]  vco_drive;      // vco output strength
    dpg_dac_t    i_dac;          // i dac sleep, power-down, gain
    dpg_dac_t    q_dac;          // q dac sleep, power-down, gain
    dpg_aux_t    aux1;           // aux dac sign, direction, power, data

    // settled control voltage code from the analog side
    logic [2:0]  vco_volt;

    // address decode
    logic        hit_pll;        // request targets the pll word
    logic        hit_idac;       // request targets the i dac word
    logic        hit_aux1;       // request targets the aux dac word
    logic        hit_qdac;       // request targets the q dac word
    logic        hit_any;        // request targets a mapped word
    logic        wr_pll;         // write strobe to the pll word
    logic        wr_idac;        // write strobe to the i dac word
    logic        wr_aux1;        // write strobe to the aux dac word
    logic        wr_qdac;        // write strobe to the q dac word

    // read path
    logic [`DPG_DATA_W-1:0] next_rdata; // word chosen for read-back

    // the analog control voltage has no relation to clk_i, so it is
    // brought in through three stages before software may see it
    dpg_level_sync #(
        .WIDTH     (3)
    ) u_volt_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .level_i   (vco_volt_level_i),
        .level_o   (vco_volt)
    );

    // decode the address once; every register takes one whole offset
    always_comb begin
        hit_pll  = (req_i.addr == `DPG_ADDR_PLL);
        hit_idac = (req_i.addr == `DPG_ADDR_IDAC);
        hit_aux1 = (req_i.addr == `DPG_ADDR_AUX1);
        hit_qdac = (req_i.addr == `DPG_ADDR_QDAC);
        hit_any  = hit_pll | hit_idac | hit_aux1 | hit_qdac;
        wr_pll   = req_i.wr & hit_pll;
        wr_idac  = req_i.wr & hit_idac;
        wr_aux1  = req_i.wr & hit_aux1;
        wr_qdac  = req_i.wr & hit_qdac;
    end

    // pll control word: all fields but the voltage code are writable;
    // bits at the voltage code position are ignored on write so a
    // stray write cannot disturb the readback
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            loop_bw   <= `DPG_RST_LBW;
            pll_en    <= `DPG_RST_PLL_EN;  // multiplier off [RULE_01]
            vco_div   <= `DPG_RST_VDIV;
            loop_div  <= `DPG_RST_LDIV;
            bias      <= `DPG_RST_BIAS;
            band      <= `DPG_RST_BAND;
            vco_drive <= `DPG_RST_DRV;
        end else if (wr_pll) begin
            // bandwidth, bias and drive take whatever software writes;
            // the advised settings are software's to choose
            loop_bw   <= req_i.wdata[`DPG_PLL_LBW_MSB:`DPG_PLL_LBW_LSB];
            pll_en    <= req_i.wdata[`DPG_PLL_EN_BIT];    // [RULE_02]
            vco_div   <= req_i.wdata[`DPG_PLL_VDIV_MSB:`DPG_PLL_VDIV_LSB];
            loop_div  <= req_i.wdata[`DPG_PLL_LDIV_MSB:`DPG_PLL_LDIV_LSB];
            bias      <= req_i.wdata[`DPG_PLL_BIAS_MSB:`DPG_PLL_BIAS_LSB];
            band      <= req_i.wdata[`DPG_PLL_BAND_MSB:`DPG_PLL_BAND_LSB];
            vco_drive <= req_i.wdata[`DPG_PLL_DRV_MSB:`DPG_PLL_DRV_LSB];
        end
    end

    // i dac control; reserved bits are not stored at all [RULE_17]
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            i_dac.sleep <= `DPG_RST_BIT;   // active after reset [RULE_10]
            i_dac.pdown <= `DPG_RST_BIT;   // active after reset [RULE_11]
            i_dac.gain  <= `DPG_RST_GAIN;
        end else if (wr_idac) begin
            i_dac.sleep <= req_i.wdata[`DPG_DAC_SLEEP_BIT];  // [RULE_10]
            i_dac.pdown <= req_i.wdata[`DPG_DAC_PDOWN_BIT];  // [RULE_11]
            i_dac.gain  <= req_i.wdata[`DPG_DAC_GAIN_MSB:`DPG_DAC_GAIN_LSB];
        end
    end

    // q dac control uses the same layout as the i dac [RULE_19]
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            q_dac.sleep <= `DPG_RST_BIT;
            q_dac.pdown <= `DPG_RST_BIT;
            q_dac.gain  <= `DPG_RST_GAIN;
        end else if (wr_qdac) begin
            q_dac.sleep <= req_i.wdata[`DPG_DAC_SLEEP_BIT];  // [RULE_19]
            q_dac.pdown <= req_i.wdata[`DPG_DAC_PDOWN_BIT];
            q_dac.gain  <= req_i.wdata[`DPG_DAC_GAIN_MSB:`DPG_DAC_GAIN_LSB];
        end
    end

    // first auxiliary dac control
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aux1.sign  <= `DPG_RST_BIT;    // positive pin [RULE_13]
            aux1.sink  <= `DPG_RST_BIT;    // sourcing [RULE_14]
            aux1.pdown <= `DPG_RST_BIT;    // active [RULE_15]
            aux1.data  <= `DPG_RST_GAIN;
        end else if (wr_aux1) begin
            aux1.sign  <= req_i.wdata[`DPG_AUX_SIGN_BIT];    // [RULE_13]
            aux1.sink  <= req_i.wdata[`DPG_AUX_SINK_BIT];    // [RULE_14]
            aux1.pdown <= req_i.wdata[`DPG_AUX_PDOWN_BIT];   // [RULE_15]
            aux1.data  <= req_i.wdata[`DPG_AUX_DATA_MSB:`DPG_AUX_DATA_LSB];
        end
    end

    // read-back mux; reserved bits and unmapped offsets read as zero
    always_comb begin
        next_rdata = '0;
        if (hit_pll) begin
            // the voltage code is live from the analog side [RULE_05]
            next_rdata[`DPG_PLL_VOLT_MSB:`DPG_PLL_VOLT_LSB] = vco_volt;
            next_rdata[`DPG_PLL_LBW_MSB:`DPG_PLL_LBW_LSB]   = loop_bw;
            next_rdata[`DPG_PLL_EN_BIT]                     = pll_en;
            next_rdata[`DPG_PLL_VDIV_MSB:`DPG_PLL_VDIV_LSB] = vco_div;
            next_rdata[`DPG_PLL_LDIV_MSB:`DPG_PLL_LDIV_LSB] = loop_div;
            next_rdata[`DPG_PLL_BIAS_MSB:`DPG_PLL_BIAS_LSB] = bias;
            next_rdata[`DPG_PLL_BAND_MSB:`DPG_PLL_BAND_LSB] = band;
            next_rdata[`DPG_PLL_DRV_MSB:`DPG_PLL_DRV_LSB]   = vco_drive;
        end else if (hit_idac) begin
            next_rdata[`DPG_DAC_SLEEP_BIT] = i_dac.sleep;
            next_rdata[`DPG_DAC_PDOWN_BIT] = i_dac.pdown;
            next_rdata[`DPG_DAC_GAIN_MSB:`DPG_DAC_GAIN_LSB] = i_dac.gain;
        end else if (hit_aux1) begin
            next_rdata[`DPG_AUX_SIGN_BIT]  = aux1.sign;
            next_rdata[`DPG_AUX_SINK_BIT]  = aux1.sink;
            next_rdata[`DPG_AUX_PDOWN_BIT] = aux1.pdown;
            next_rdata[`DPG_AUX_DATA_MSB:`DPG_AUX_DATA_LSB] = aux1.data;
        end else if (hit_qdac) begin
            next_rdata[`DPG_DAC_SLEEP_BIT] = q_dac.sleep;
            next_rdata[`DPG_DAC_PDOWN_BIT] = q_dac.pdown;
            next_rdata[`DPG_DAC_GAIN_MSB:`DPG_DAC_GAIN_LSB] = q_dac.gain;
        end else begin
            next_rdata = '0;    // unmapped offset
        end
    end

    // answer every strobe one cycle later; a read taken together with a
    // write to the same word returns the value before the write
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rsp_o <= '0;
        end else begin
            rsp_o.valid <= req_i.wr | req_i.rd;
            rsp_o.err   <= (req_i.wr | req_i.rd) & ~hit_any;
            // hold the last read data so the engine may shift it out late
            if (req_i.rd) begin
                rsp_o.rdata <= next_rdata;
            end
        end
    end

    // field outputs to the analog periphery: one register stage, no
    // processing, so the edge sees exactly what software wrote [RULE_18]
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pll_o   <= '0;
            i_dac_o <= '0;
            q_dac_o <= '0;
            aux1_o  <= '0;
        end else begin
            pll_o.vco_volt  <= vco_volt;
            pll_o.loop_bw   <= loop_bw;
            pll_o.pll_en    <= pll_en;
            pll_o.vco_div   <= vco_div;
            pll_o.loop_div  <= loop_div;
            pll_o.bias      <= bias;
            pll_o.band      <= band;                    // [RULE_08]
            pll_o.vco_drive <= vco_drive;
            i_dac_o         <= i_dac;                   // [RULE_12]
            q_dac_o         <= q_dac;                   // [RULE_19]
            aux1_o          <= aux1;                    // [RULE_16]
        end
    end

    // sample clock source: reference input while the multiplier is off,
    // multiplier output once it is on; the analog mux switches on this
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dac_clk_from_pll_o <= 1'h0;                 // [RULE_01]
        end else begin
            dac_clk_from_pll_o <= pll_en;               // [RULE_01] [RULE_02]
        end
    end

    // decoded divider ratios, so the clock tree needs no decoder of its
    // own; a shift keeps the power-of-two mapping exact
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            vco_div_ratio_o  <= `DPG_VRATIO_BASE;
            loop_div_ratio_o <= `DPG_LRATIO_BASE;
        end else begin
            vco_div_ratio_o  <= `DPG_VRATIO_BASE << vco_div;   // [RULE_03]
            loop_div_ratio_o <= `DPG_LRATIO_BASE << loop_div;  // [RULE_04]
        end
    end

    // per-channel enables: either low-power bit stops the channel
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            i_dac_active_o <= 1'h1;
            q_dac_active_o <= 1'h1;
            aux1_active_o  <= 1'h1;
        end else begin
            i_dac_active_o <= ~(i_dac.sleep | i_dac.pdown); // [RULE_10] [RULE_11]
            q_dac_active_o <= ~(q_dac.sleep | q_dac.pdown); // [RULE_19]
            aux1_active_o  <= ~aux1.pdown;                  // [RULE_15]
        end
    end

    // aux output pin choice: exactly one pin drives while active; a
    // powered-down dac drives neither, avoiding a stray offset current
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aux1_pos_pin_en_o <= 1'h1;
            aux1_neg_pin_en_o <= 1'h0;
        end else begin
            aux1_pos_pin_en_o <= ~aux1.sign & ~aux1.pdown;  // [RULE_13]
            aux1_neg_pin_en_o <=  aux1.sign & ~aux1.pdown;  // [RULE_13]
        end
    end

endmodule : dpg_ctrl_regs

// ===== dpg_consts.svh
// constants for the dac pll and gain control register bank:
// register offsets, field positions, widths and reset values.
// assumes it is included by bare name from the package and the modules.
`ifndef DPG_CONSTS_SVH
`define DPG_CONSTS_SVH

// register port widths
`define DPG_ADDR_W          8
`define DPG_DATA_W          24

// register offsets on the serial port register map
`define DPG_ADDR_PLL        8'h04
`define DPG_ADDR_IDAC       8'h05
`define DPG_ADDR_AUX1       8'h06
`define DPG_ADDR_QDAC       8'h07

// pll control word field positions
`define DPG_PLL_VOLT_MSB    23
`define DPG_PLL_VOLT_LSB    21
`define DPG_PLL_LBW_MSB     20
`define DPG_PLL_LBW_LSB     16
`define DPG_PLL_EN_BIT      15
`define DPG_PLL_VDIV_MSB    14
`define DPG_PLL_VDIV_LSB    13
`define DPG_PLL_LDIV_MSB    12
`define DPG_PLL_LDIV_LSB    11
`define DPG_PLL_BIAS_MSB    10
`define DPG_PLL_BIAS_LSB    8
`define DPG_PLL_BAND_MSB    7
`define DPG_PLL_BAND_LSB    2
`define DPG_PLL_DRV_MSB     1
`define DPG_PLL_DRV_LSB     0

// i and q dac control field positions
`define DPG_DAC_SLEEP_BIT   15
`define DPG_DAC_PDOWN_BIT   14
`define DPG_DAC_GAIN_MSB    9
`define DPG_DAC_GAIN_LSB    0

// auxiliary dac one field positions
`define DPG_AUX_SIGN_BIT    15
`define DPG_AUX_SINK_BIT    14
`define DPG_AUX_PDOWN_BIT   13
`define DPG_AUX_DATA_MSB    9
`define DPG_AUX_DATA_LSB    0

// reset values of the register fields
`define DPG_RST_LBW         5'h00
`define DPG_RST_PLL_EN      1'h0
`define DPG_RST_VDIV        2'h0
`define DPG_RST_LDIV        2'h0
`define DPG_RST_BIAS        3'h0
`define DPG_RST_BAND        6'h00
`define DPG_RST_DRV         2'h0
`define DPG_RST_BIT         1'h0
`define DPG_RST_GAIN        10'h000
`define DPG_RST_VOLT        3'h0

// divider ratio encodings: vco ratio is 1 << code, loop ratio 2 << code
`define DPG_VRATIO_W        4
`define DPG_LRATIO_W        5
`define DPG_VRATIO_BASE     4'h1
`define DPG_LRATIO_BASE     5'h02

`endif

// ===== dpg_pkg.sv
// types shared by the dac pll and gain control register bank.
// assumes dpg_consts.svh is on the include path.
`include "dpg_consts.svh"

package dpg_pkg;

    // pll control word, bit for bit in register layout order
    typedef struct packed {
        logic [2:0] vco_volt;   // read-only control voltage code
        logic [4:0] loop_bw;    // loop filter bandwidth
        logic       pll_en;     // clock multiplier enable
        logic [1:0] vco_div;    // vco output divider code
        logic [1:0] loop_div;   // loop divider code
        logic [2:0] bias;       // vco bias current
        logic [5:0] band;       // vco band select
        logic [1:0] vco_drive;  // vco output strength
    } dpg_pll_t;

    // i or q main dac control
    typedef struct packed {
        logic       sleep;      // low-power sleep
        logic       pdown;      // power-down
        logic [9:0] gain;       // gain adjustment
    } dpg_dac_t;

    // auxiliary dac control
    typedef struct packed {
        logic       sign;       // 1 selects negative pin
        logic       sink;       // 1 sinks current
        logic       pdown;      // power-down
        logic [9:0] data;       // gain adjustment data
    } dpg_aux_t;

    // register request from the serial port engine
    typedef struct packed {
        logic                   wr;
        logic                   rd;
        logic [`DPG_ADDR_W-1:0] addr;
        logic [`DPG_DATA_W-1:0] wdata;
    } dpg_req_t;

    // register answer back to the serial port engine
    typedef struct packed {
        logic                   valid;
        logic                   err;
        logic [`DPG_DATA_W-1:0] rdata;
    } dpg_rsp_t;

endpackage : dpg_pkg

// ===== dpg_level_sync.sv
// three-stage synchroniser for a slow multi-bit analog status level.
// assumes the level changes rarely; a new value is taken only once the
// second and third stages agree, so a word seen mid-change is never used.
`timescale 1ns/1ns
`include "dpg_consts.svh"

module dpg_level_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // asynchronous level in, settled level out
    input  wire logic [WIDTH-1:0] level_i,
    output logic      [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] stage1;   // metastability catcher, read by stage2 only
    logic [WIDTH-1:0] stage2;   // second stage
    logic [WIDTH-1:0] stage3;   // third stage

    // refuse a width that carries nothing
    if (WIDTH < 1) begin : g_bad_width
        $error("dpg_level_sync: WIDTH must be at least 1");
    end

    // shift chain
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= level_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // accept only a word that held still for two samples
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            level_o <= '0;
        end else if (stage2 == stage3) begin
            level_o <= stage3;
        end
    end

endmodule : dpg_level_sync

// ===== dpg_ctrl_checker.sv
// concurrent checks for the dpg register bank, seen from its ports.
// assumes it is bound onto dpg_ctrl_regs, one clock domain.
`timescale 1ns/1ns
`include "dpg_consts.svh"

module dpg_ctrl_checker (
    // clock and reset
    input wire logic                     clk_i,
    input wire logic                     reset_n_i,
    // register port and analog status
    input dpg_pkg::dpg_req_t             req_i,
    input dpg_pkg::dpg_rsp_t             rsp_o,
    input wire logic [2:0]               vco_volt_level_i,
    // outputs to the analog periphery
    input dpg_pkg::dpg_pll_t             pll_o,
    input wire logic                     dac_clk_from_pll_o,
    input wire logic [`DPG_VRATIO_W-1:0] vco_div_ratio_o,
    input wire logic [`DPG_LRATIO_W-1:0] loop_div_ratio_o,
    input dpg_pkg::dpg_dac_t             i_dac_o,
    input dpg_pkg::dpg_dac_t             q_dac_o,
    input wire logic                     i_dac_active_o,
    input wire logic                     q_dac_active_o,
    input dpg_pkg::dpg_aux_t             aux1_o,
    input wire logic                     aux1_pos_pin_en_o,
    input wire logic                     aux1_neg_pin_en_o,
    input wire logic                     aux1_active_o
);
    import dpg_pkg::*;

    // all checks share one clock and its reset
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // helper terms
    logic any_req;   // a request taken at this edge
    logic mapped;    // offset inside the bank
    assign any_req = req_i.wr | req_i.rd;
    assign mapped = req_i.addr inside {[8'h04:8'h07]};

    rsp_pulse_a: assert property (
        any_req |=> rsp_o.valid && (rsp_o.err == !$past(mapped)))
        else $error("answer missing or error flag wrong");
    clk_src_a: assert property (
        dac_clk_from_pll_o == pll_o.pll_en)
        else $error("clock source wrong");
    vco_ratio_a: assert property (
        vco_div_ratio_o == (`DPG_VRATIO_BASE << pll_o.vco_div))
        else $error("vco divider ratio wrong");
    loop_ratio_a: assert property (
        loop_div_ratio_o == (`DPG_LRATIO_BASE << pll_o.loop_div))
        else $error("loop divider ratio wrong");
    // the sync settles in four edges, the output register adds a fifth
    volt_track_a: assert property (
        $stable(vco_volt_level_i) [*8] |-> pll_o.vco_volt == vco_volt_level_i)
        else $error("volt code stale");
    pll_write_a: assert property (
        req_i.wr && req_i.addr == 8'h04 |=> ##1
        pll_o[20:0] == $past(req_i.wdata[20:0], 2))
        else $error("pll word lost");
    idac_write_a: assert property (
        req_i.wr && req_i.addr == 8'h05 |=> ##1 i_dac_o ==
        {$past(req_i.wdata[15:14], 2), $past(req_i.wdata[9:0], 2)})
        else $error("i dac word lost");
    qdac_write_a: assert property (
        req_i.wr && req_i.addr == 8'h07 |=> ##1 q_dac_o ==
        {$past(req_i.wdata[15:14], 2), $past(req_i.wdata[9:0], 2)})
        else $error("q dac word lost");
    aux_write_a: assert property (
        req_i.wr && req_i.addr == 8'h06 |=> ##1 aux1_o ==
        {$past(req_i.wdata[15:13], 2), $past(req_i.wdata[9:0], 2)})
        else $error("aux dac word lost");
    dac_active_a: assert property (
        i_dac_active_o == !(i_dac_o.sleep | i_dac_o.pdown) &&
        q_dac_active_o == !(q_dac_o.sleep | q_dac_o.pdown))
        else $error("dac active level wrong");
    aux_pins_a: assert property (
        {aux1_pos_pin_en_o, aux1_neg_pin_en_o, aux1_active_o} ==
        {!aux1_o.sign && !aux1_o.pdown, aux1_o.sign && !aux1_o.pdown,
         !aux1_o.pdown})
        else $error("aux pin enables wrong");

endmodule : dpg_ctrl_checker

bind dpg_ctrl_regs dpg_ctrl_checker i_chk (.*);

// ===== dpg_ctrl_regs_tb_top.sv
// self-checking bench for the dpg register bank.
// assumes dpg_ctrl_regs with its checker bound; the bench is the engine.
`timescale 1ns/1ns
`include "dpg_consts.svh"

module dpg_ctrl_regs_tb_top;
    import dpg_pkg::*;

    // design connections
    logic                     clk_i;
    logic                     reset_n_i;
    dpg_req_t                 req_i;
    dpg_rsp_t                 rsp_o;
    logic [2:0]               vco_volt_level_i;
    dpg_pll_t                 pll_o;
    logic                     dac_clk_from_pll_o;
    logic [`DPG_VRATIO_W-1:0] vco_div_ratio_o;
    logic [`DPG_LRATIO_W-1:0] loop_div_ratio_o;
    dpg_dac_t                 i_dac_o;
    dpg_dac_t                 q_dac_o;
    logic                     i_dac_active_o;
    logic                     q_dac_active_o;
    dpg_aux_t                 aux1_o;
    logic                     aux1_pos_pin_en_o;
    logic                     aux1_neg_pin_en_o;
    logic                     aux1_active_o;
    // bench state
    logic [25:0]              exp_q[$];  // {data checked, err, rdata}
    logic [25:0]              got_e;     // note taken off the queue
    logic [23:0]              shadow[4]; // expected words, volt aside
    logic [23:0]              d;         // scratch write data
    int                       bad_count = 0;
    int                       cmp_count = 0;

    dpg_ctrl_regs i_dut (.*);

    // 250 MHz clock
    initial clk_i = 1'b0;
    always #2 clk_i = ~clk_i;

    // one comparison, counted; case equality so unknowns fail
    task automatic cmp(input string what, input logic [23:0] e, g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", what, e, g);
        end
    endtask : cmp

    // writable bits of each word
    function automatic logic [23:0] msk(input logic [1:0] i);
        return (i == 2'd0) ? 24'h1FFFFF : (i[0] ? 24'h00C3FF : 24'h00E3FF);
    endfunction : msk

    // one request; answer noted before the shadow update
    task automatic op(input logic w, r, input logic [7:0] a,
                      input logic [23:0] dat);
        logic ok;
        ok = a inside {[8'h04:8'h07]};
        @(posedge clk_i);
        #1;
        req_i = {w, r, a, dat};
        exp_q.push_back({r, !ok, (r && ok) ? (shadow[a[1:0]] |
            ((a == 8'h04) ? {vco_volt_level_i, 21'h0} : 24'h0)) : 24'h0});
        if (w && ok) begin
            shadow[a[1:0]] = dat & msk(a[1:0]);
        end
    endtask : op

    // idle cycles with the strobes low
    task automatic rest(input int n);
        repeat (n) begin
            @(posedge clk_i);
            #1;
            req_i = '0;
        end
    endtask : rest

    // static outputs against the shadow words
    task automatic check_out();
        cmp("pll fields", shadow[0][20:0], pll_o[20:0]);
        cmp("volt code", vco_volt_level_i, pll_o.vco_volt);
        cmp("pll source", shadow[0][15], dac_clk_from_pll_o);
        cmp("vco ratio", 24'h1 << shadow[0][14:13], vco_div_ratio_o);
        cmp("loop ratio", 24'h2 << shadow[0][12:11], loop_div_ratio_o);
        cmp("i dac", {shadow[1][15:14], shadow[1][9:0]}, i_dac_o);
        cmp("q dac", {shadow[3][15:14], shadow[3][9:0]}, q_dac_o);
        cmp("dac active", {~|shadow[1][15:14], ~|shadow[3][15:14]},
            {i_dac_active_o, q_dac_active_o});
        cmp("aux", {shadow[2][15:13], shadow[2][9:0]}, aux1_o);
        cmp("aux pins", {!shadow[2][15] && !shadow[2][13],
            shadow[2][15] && !shadow[2][13], !shadow[2][13]},
            {aux1_pos_pin_en_o, aux1_neg_pin_en_o, aux1_active_o});
    endtask : check_out

    // answer watcher: oldest note against each valid pulse
    always @(posedge clk_i) begin
        if (reset_n_i === 1'b1 && rsp_o.valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp("spare answer", 24'h0, 24'h1);
            end else begin
                got_e = exp_q.pop_front();
                cmp("answer err", got_e[24], rsp_o.err);
                if (got_e[25]) begin
                    cmp("read data", got_e[23:0], rsp_o.rdata);
                end
            end
        end
    end

    // verdict and end of run
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    // run limit
    initial begin
        #200000;
        cmp("run limit", 24'h0, 24'h1);
        close_out();
    end

    // main sequence
    initial begin
        reset_n_i = 1'b0;
        req_i = '0;
        vco_volt_level_i = 3'h3;
        foreach (shadow[k]) shadow[k] = '0;
        void'($urandom(32'h285ed356));
        repeat (3) @(posedge clk_i);
        #1;
        reset_n_i = 1'b1;
        rest(10);
        check_out();
        for (int a = 3; a < 9; a++) op(1'b0, 1'b1, a[7:0], 24'h0);
        // every divider code, enable both ways, read-only bits written 1
        for (int k = 0; k < 4; k++) begin
            d = $urandom;
            d[23:11] = {3'h7, d[20:16], k[0], k[1:0], k[1:0]};
            op(1'b1, 1'b0, 8'h04, d);
            op(1'b0, 1'b1, 8'h04, 24'h0);
            rest(2);
            check_out();
        end
        op(1'b1, 1'b1, 8'h04, 24'h0F83AB);
        // all sleep, power-down, sign and direction mixes, reserved set
        for (int k = 0; k < 8; k++) begin
            d = $urandom | 24'h003C00;
            d[15:13] = k[2:0];
            for (int a = 5; a < 8; a++) op(1'b1, 1'b0, a[7:0], d);
            op(1'b1, 1'b1, 8'h05, ~d);
            for (int a = 4; a < 8; a++) op(1'b0, 1'b1, a[7:0], 24'h0);
            rest(2);
            check_out();
        end
        // unmapped writes leave every word alone
        op(1'b1, 1'b0, 8'h08, 24'hFFFFFF);
        op(1'b1, 1'b0, 8'h00, 24'hFFFFFF);
        vco_volt_level_i = $urandom;
        rest(10);
        check_out();
        op(1'b0, 1'b1, 8'h04, 24'h0);
        rest(3);
        // reset in mid-run returns the defaults
        reset_n_i = 1'b0;
        foreach (shadow[k]) shadow[k] = '0;
        rest(3);
        reset_n_i = 1'b1;
        rest(10);
        check_out();
        for (int n = 0; n < 50 && exp_q.size() != 0; n++) @(posedge clk_i);
        if (exp_q.size() != 0) begin
            cmp("missing answers", 24'h0, 24'h1);
        end
        close_out();
    end

endmodule : dpg_ctrl_regs_tb_top
